// file: shared/ict_pkg.sv
// instruction cycle timing package: operation codes, timing entries, counts
// assumes: one processor clock, four clocks per bus cycle without waits
package ict_pkg;

  localparam int CLK_MHZ       = 50;
  localparam int BUS_CLKS      = 4;
  localparam int CNT_W         = 12;
  localparam int RW_W          = 8;
  localparam int OP_W          = 6;
  localparam int RESET_CLKS    = 40;
  localparam int RESET_READS   = 6;
  localparam int NREG_W        = 5;

  typedef enum logic [OP_W-1:0] {
    ICT_BIT_INVERT, ICT_BIT_ZERO, ICT_BIT_ONE, ICT_BIT_PROBE,
    ICT_COND_BRANCH, ICT_ALWAYS_BRANCH, ICT_BRANCH_CALL,
    ICT_COUNT_LOOP, ICT_JUMP, ICT_CALL, ICT_ADDR_LOAD, ICT_ADDR_PUSH,
    ICT_MULTI_LOAD, ICT_MULTI_STORE, ICT_EXT_ADD, ICT_EXT_SUB,
    ICT_MEM_COMPARE, ICT_DEC_ADD, ICT_DEC_SUB, ICT_LOGIC_IMM_STATUS,
    ICT_STATUS_LOAD, ICT_CC_LOAD, ICT_STATUS_STORE, ICT_EXT_RESET,
    ICT_EXC_RETURN, ICT_CC_RESTORE_RETURN, ICT_SUB_RETURN,
    ICT_FRAME_ALLOC, ICT_FRAME_FREE, ICT_STOP, ICT_IDLE, ICT_SWAP_HALVES,
    ICT_SIGN_WIDEN, ICT_OVERFLOW_TRAP, ICT_USP_MOVE, ICT_REG_EXCHANGE,
    ICT_BOUNDS_CHECK, ICT_PERIPH_MOVE, ICT_EXC_ADDR_ERR, ICT_EXC_BUS_ERR,
    ICT_EXC_SIMPLE, ICT_EXC_BOUNDS, ICT_EXC_DIV_ZERO, ICT_EXC_INTERRUPT
  } ict_op_t;

  // request: operation plus its variant flags and address-time share
  typedef struct packed {
    ict_op_t          op;
    logic             is_long;
    logic             is_mem;
    logic             is_static;
    logic             alt;
    logic             alt2;
    logic [NREG_W-1:0] nregs;
    logic [CNT_W-1:0] ea_clks;
    logic [RW_W-1:0]  ea_reads;
  } ict_req_t;

  // one timing entry: clocks, reads, writes, address time added
  typedef struct packed {
    logic [CNT_W-1:0] clks;
    logic [RW_W-1:0]  reads;
    logic [RW_W-1:0]  writes;
    logic             add_ea;
  } ict_entry_t;

  typedef enum logic [1:0] {ICT_CYC_NONE, ICT_CYC_READ, ICT_CYC_WRITE}
    ict_cyc_t;

endpackage

// file: design/ict_table.sv
// timing lookup: maps a request to its base clocks, reads and writes
// assumes: purely combinational, request held stable by the caller
`timescale 1ns/1ps
`default_nettype none
module ict_table (
  // request in
  input  wire ict_pkg::ict_req_t   req,
  // timing entry out
  output var  ict_pkg::ict_entry_t ent
);
  import ict_pkg::*;

  function automatic ict_entry_t mk(input int c, input int r, input int w,
                                    input logic a);
    ict_entry_t e;
    e.clks   = CNT_W'(c);
    e.reads  = RW_W'(r);
    e.writes = RW_W'(w);
    e.add_ea = a;
    return e;
  endfunction

  int n;
  always_comb begin
    n   = int'(req.nregs);
    ent = mk(4, 1, 0, 1'b0);
    case (req.op)
      ICT_BIT_INVERT, ICT_BIT_ONE, ICT_BIT_ZERO: begin
        if (req.is_mem) begin
          ent = req.is_static ? mk(12, 2, 1, 1'b1) : mk(8, 1, 1, 1'b1); // RQ2 RQ3
        end else if (req.op == ICT_BIT_ZERO) begin
          ent = req.is_static ? mk(14, 2, 0, 1'b0) : mk(10, 1, 0, 1'b0); // RQ3 RQ5
        end else begin
          ent = req.is_static ? mk(12, 2, 0, 1'b0) : mk(8, 1, 0, 1'b0); // RQ2 RQ5
        end
      end
      ICT_BIT_PROBE: begin
        if (req.is_mem) begin
          ent = req.is_static ? mk(8, 2, 0, 1'b1) : mk(4, 1, 0, 1'b1); // RQ4
        end else begin
          ent = req.is_static ? mk(10, 2, 0, 1'b0) : mk(6, 1, 0, 1'b0); // RQ4
        end
      end
      ICT_COND_BRANCH: begin
        if (req.alt) ent = mk(10, 2, 0, 1'b0); // RQ6
        else if (req.is_long) ent = mk(12, 2, 0, 1'b0); // RQ6
        else ent = mk(8, 1, 0, 1'b0); // RQ6
      end
      ICT_ALWAYS_BRANCH: ent = mk(10, 2, 0, 1'b0); // RQ6
      ICT_BRANCH_CALL:   ent = mk(18, 2, 2, 1'b0); // RQ6
      ICT_COUNT_LOOP: begin
        if (req.alt) ent = mk(12, 2, 0, 1'b0); // RQ7
        else if (req.alt2) ent = mk(14, 3, 0, 1'b0); // RQ7
        else ent = mk(10, 2, 0, 1'b0); // RQ7
      end
      ICT_JUMP: ent = mk(8, 2, 0, 1'b0); // RQ8
      ICT_CALL: ent = req.alt ? mk(20, 3, 2, 1'b0) : mk(16, 2, 2, 1'b0); // RQ8
      ICT_ADDR_LOAD: ent = mk(4, 1, 0, 1'b0); // RQ9
      ICT_ADDR_PUSH: ent = mk(12, 1, 2, 1'b0); // RQ9
      ICT_MULTI_LOAD: ent = req.is_long ? mk(12 + 8 * n, 3 + 2 * n, 0, 1'b0)
                                        : mk(12 + 4 * n, 3 + n, 0, 1'b0); // RQ10
      ICT_MULTI_STORE: ent = req.is_long ? mk(8 + 8 * n, 2, 2 * n, 1'b0)
                                         : mk(8 + 4 * n, 2, n, 1'b0); // RQ11
      ICT_EXT_ADD, ICT_EXT_SUB: begin
        if (req.is_mem) ent = req.is_long ? mk(30, 5, 2, 1'b0)
                                          : mk(18, 3, 1, 1'b0); // RQ13
        else ent = req.is_long ? mk(8, 1, 0, 1'b0) : mk(4, 1, 0, 1'b0); // RQ13
      end
      ICT_MEM_COMPARE: ent = req.is_long ? mk(20, 5, 0, 1'b0)
                                         : mk(12, 3, 0, 1'b0); // RQ14
      ICT_DEC_ADD, ICT_DEC_SUB: ent = req.is_mem ? mk(18, 3, 1, 1'b0)
                                                 : mk(6, 1, 0, 1'b0); // RQ14
      ICT_LOGIC_IMM_STATUS: ent = mk(20, 3, 0, 1'b0); // RQ15
      ICT_STATUS_LOAD:  ent = mk(12, 2, 0, 1'b0); // RQ15
      ICT_CC_LOAD:      ent = mk(12, 1, 0, 1'b0); // RQ15
      ICT_STATUS_STORE: ent = mk(6, 1, 0, 1'b0); // RQ15
      ICT_EXT_RESET:    ent = mk(132, 1, 0, 1'b0); // RQ16
      ICT_EXC_RETURN:   ent = mk(20, 5, 0, 1'b0); // RQ17
      ICT_CC_RESTORE_RETURN: ent = mk(20, 2, 0, 1'b0); // RQ17
      ICT_SUB_RETURN:   ent = mk(16, 4, 0, 1'b0); // RQ17
      ICT_FRAME_ALLOC:  ent = mk(16, 2, 2, 1'b0); // RQ17
      ICT_FRAME_FREE:   ent = mk(12, 3, 0, 1'b0); // RQ17
      ICT_STOP:         ent = mk(4, 0, 0, 1'b0); // RQ18
      ICT_IDLE, ICT_SWAP_HALVES, ICT_SIGN_WIDEN, ICT_OVERFLOW_TRAP,
      ICT_USP_MOVE:     ent = mk(4, 1, 0, 1'b0); // RQ18
      ICT_REG_EXCHANGE: ent = mk(6, 1, 0, 1'b0); // RQ18
      ICT_BOUNDS_CHECK: ent = mk(10, 1, 0, 1'b1); // RQ18
      ICT_PERIPH_MOVE: begin
        if (req.alt) ent = req.is_long ? mk(24, 6, 0, 1'b0)
                                       : mk(16, 4, 0, 1'b0); // RQ19
        else ent = req.is_long ? mk(24, 2, 4, 1'b0)
                               : mk(16, 2, 2, 1'b0); // RQ19
      end
      ICT_EXC_ADDR_ERR, ICT_EXC_BUS_ERR: ent = mk(50, 4, 7, 1'b0); // RQ20
      ICT_EXC_SIMPLE:    ent = mk(34, 4, 3, 1'b0); // RQ20
      ICT_EXC_BOUNDS:    ent = mk(40, 4, 3, 1'b1); // RQ20
      ICT_EXC_DIV_ZERO:  ent = mk(38, 4, 3, 1'b1); // RQ20
      ICT_EXC_INTERRUPT: ent = mk(44, 5, 3, 1'b0); // RQ21
      default: ent = mk(4, 1, 0, 1'b0);
    endcase
  end

endmodule
`default_nettype wire

// file: design/ict_sequencer.sv
// Function
// RQ1: flagged entries add operand address time
// RQ2: bit invert/set: 8 or 12 clocks
// RQ3: bit clear register: 10 or 14 clocks
// RQ4: bit probe: 6/10 register, 4/8 memory
// RQ5: register bit counts are data-mode maxima
// RQ6: branch taken 10, not taken 8/12
// RQ7: loop branch 12, 10 or 14 clocks
// RQ8: jump 8, call 16, long call 20
// RQ9: address load 4, address push 12
// RQ10: multi load 12+4n or 12+8n
// RQ11: multi store 8+4n or 8+8n
// RQ12: index size never changes clock count
// RQ13: extended add/sub 4/8 or 18/30
// RQ14: compare 12/20, decimal 6 or 18
// RQ15: status logic 20, loads 12, store 6
// RQ16: external reset 132 clocks, one read
// RQ17: returns and frame ops fixed counts
// RQ18: stop 4 no bus, short ops listed
// RQ19: peripheral move 16 word, 24 long
// RQ20: exception entry includes stacking and fetch
// RQ21: interrupt entry 44, ack counted four
// RQ22: 40 clocks, six reads after reset release
// RQ23: bus cycle four clocks, waits add
// RQ24: leftover clocks are idle, no bus
//
// instruction cycle sequencer: plays out one operation's bus cycles
// assumes: inputs synchronous to CLK, wait states via BUS_WAIT
`timescale 1ns/1ps
`default_nettype none
module ict_sequencer #(
  parameter int MAX_REGS = 16
) (
  // clock, reset, enable
  input  wire  logic             CLK,
  input  wire  logic             RESET_N,
  input  wire  logic             CLK_EN,
  // start-up release
  input  wire  logic             RELEASED,
  // operation request
  input  wire  logic             REQ_VALID,
  input  wire  ict_pkg::ict_req_t REQ,
  output logic                   REQ_READY,
  // processor bus
  input  wire  logic             BUS_WAIT,
  output logic                   BUS_READ,
  output logic                   BUS_WRITE,
  output logic                   BUS_START,
  // progress
  output logic                   BUSY,
  output logic                   DONE,
  output logic                   FIRST_FETCH,
  output logic [ict_pkg::CNT_W-1:0] CLK_COUNT
);
  import ict_pkg::*;

  if (MAX_REGS < 1 || MAX_REGS > (1 << NREG_W) - 1) begin : g_bad_regs
    $error("MAX_REGS out of range");
  end

  typedef enum {S_RESET, S_STARTUP, S_READY, S_RUN} ict_state_t;

  logic [1:0]       rst_sync;
  logic             rst_n;
  ict_state_t       state;
  logic [CNT_W-1:0] clk_left;
  logic [RW_W-1:0]  rd_left;
  logic [RW_W-1:0]  wr_left;
  logic [1:0]       phase;
  logic             in_cycle;
  logic             cyc_write;
  logic [CNT_W-1:0] elapsed;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ict_req_t   req_clip;
  ict_entry_t ent;
  always_comb begin
    req_clip = REQ;
    if (int'(REQ.nregs) > MAX_REGS) req_clip.nregs = NREG_W'(MAX_REGS);
  end

  // index size is not an input: it cannot alter the count
  ict_table u_table ( // RQ12
    .req (req_clip),
    .ent (ent)
  );

  wire [CNT_W-1:0] tot_clks  = ent.add_ea ? ent.clks + REQ.ea_clks
                                          : ent.clks; // RQ1
  wire [RW_W-1:0]  tot_reads = ent.add_ea ? ent.reads + REQ.ea_reads
                                          : ent.reads; // RQ1
  wire accept   = (state == S_READY) && REQ_VALID;
  wire bus_idle = !in_cycle;
  wire cyc_end  = in_cycle && (phase == 2'(BUS_CLKS - 1)) && !BUS_WAIT; // RQ23
  // reads go first, then writes; a cycle starts whenever the bus is free and one is owed
  wire need_rd  = rd_left != '0;
  wire need_wr  = wr_left != '0;
  // a wait state freezes both the bus phase and the clock budget
  wire stall    = in_cycle && BUS_WAIT; // RQ23
  // first cycle starts on the accept edge, so bus time fits the total
  wire st_rd    = (state == S_READY) ? (tot_reads != '0) : need_rd;
  wire st_wr    = (state == S_READY) ? (ent.writes != '0) : need_wr;
  wire bus_free = (state == S_READY) ? accept
                : (state != S_RESET) && (bus_idle || cyc_end);
  wire start_ok = bus_free && (st_rd || st_wr); // RQ24
  wire last_clk = (state != S_READY) && (state != S_RESET) &&
                  (clk_left <= CNT_W'(1)) && !need_rd && !need_wr &&
                  (bus_idle || cyc_end);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state     <= S_RESET;
      clk_left  <= '0;
      rd_left   <= '0;
      wr_left   <= '0;
      phase     <= 2'h0;
      in_cycle  <= 1'b0;
      cyc_write <= 1'b0;
      elapsed   <= '0;
      DONE      <= 1'b0;
      FIRST_FETCH <= 1'b0;
    end else if (CLK_EN) begin
      DONE        <= 1'b0;
      FIRST_FETCH <= 1'b0;
      case (state)
        S_RESET: begin
          if (RELEASED) begin
            state    <= S_STARTUP;
            clk_left <= CNT_W'(RESET_CLKS); // RQ22
            rd_left  <= RW_W'(RESET_READS); // RQ22
            wr_left  <= '0;
            elapsed  <= '0;
          end
        end
        S_READY: begin
          if (accept) begin
            state    <= S_RUN;
            clk_left <= tot_clks;
            rd_left  <= tot_reads;
            wr_left  <= ent.writes;
            elapsed  <= '0;
            if (start_ok) begin
              in_cycle  <= 1'b1;
              cyc_write <= !st_rd;
              phase     <= 2'h0;
              if (st_rd) rd_left <= tot_reads - RW_W'(1);
              else wr_left <= ent.writes - RW_W'(1);
            end
          end
        end
        default: begin
          elapsed <= elapsed + CNT_W'(1);
          if (clk_left != '0 && !stall) clk_left <= clk_left - CNT_W'(1);
          if (start_ok) begin
            in_cycle  <= 1'b1;
            cyc_write <= !need_rd;
            phase     <= 2'h0;
            if (need_rd) rd_left <= rd_left - RW_W'(1);
            else wr_left <= wr_left - RW_W'(1);
          end else if (cyc_end) begin
            in_cycle <= 1'b0;
            phase    <= 2'h0;
          end else if (in_cycle && !BUS_WAIT) begin
            phase <= phase + 2'h1;
          end
          if (last_clk) begin
            if (state == S_STARTUP) FIRST_FETCH <= 1'b1; // RQ22
            DONE  <= 1'b1;
            state <= S_READY;
          end
        end
      endcase
    end
  end

  // outputs registered from the state above
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUS_READ  <= 1'b0;
      BUS_WRITE <= 1'b0;
      BUS_START <= 1'b0;
      BUSY      <= 1'b0;
      REQ_READY <= 1'b0;
      CLK_COUNT <= '0;
    end else if (CLK_EN) begin
      BUS_START <= start_ok;
      BUS_READ  <= (start_ok && st_rd) ||
                   (in_cycle && !cyc_end && !cyc_write);
      BUS_WRITE <= (start_ok && !st_rd) ||
                   (in_cycle && !cyc_end && cyc_write);
      BUSY      <= !((state == S_READY && !accept) ||
                     (state == S_RESET && !RELEASED) || last_clk);
      REQ_READY <= (state == S_READY && !accept) ||
                   (state != S_READY && state != S_RESET && last_clk);
      CLK_COUNT <= (state == S_READY) ? CLK_COUNT : elapsed + CNT_W'(1);
    end
  end

  property p_stop_no_bus;
    @(posedge CLK) disable iff (!rst_n)
      (accept && CLK_EN && REQ.op == ICT_STOP) |-> ##1 !BUS_START [*4];
  endproperty
  a_stop_no_bus: assert property (p_stop_no_bus) // RQ18
    else $error("stop started a bus cycle");

  property p_startup_reads;
    @(posedge CLK) disable iff (!rst_n)
      (state == S_RESET && RELEASED && CLK_EN) |=> rd_left == RW_W'(6);
  endproperty
  a_startup_reads: assert property (p_startup_reads) // RQ22
    else $error("startup read count wrong");

  property p_cycle_len;
    @(posedge CLK) disable iff (!rst_n)
      (start_ok && CLK_EN && state != S_RESET && !BUS_WAIT)
        |=> in_cycle [*3];
  endproperty
  a_cycle_len: assert property (p_cycle_len) // RQ23
    else $error("bus cycle shorter than four clocks");

  property p_idle_no_start;
    @(posedge CLK) disable iff (!rst_n)
      (state == S_RUN && !need_rd && !need_wr) |-> !start_ok;
  endproperty
  a_idle_no_start: assert property (p_idle_no_start) // RQ24
    else $error("bus cycle started with none owed");

  property p_stop_len;
    @(posedge CLK) disable iff (!rst_n)
      (accept && CLK_EN && REQ.op == ICT_STOP) |-> ##5 DONE;
  endproperty
  a_stop_len: assert property (p_stop_len) // RQ18
    else $error("stop did not end after four clocks");

  property p_startup_len;
    @(posedge CLK) disable iff (!rst_n)
      (state == S_STARTUP && last_clk && CLK_EN)
        |-> (elapsed == CNT_W'(RESET_CLKS - 1)) && (rd_left == '0);
  endproperty
  a_startup_len: assert property (p_startup_len) // RQ22
    else $error("startup length or reads wrong");

endmodule
`default_nettype wire

// file: test/ict_mem_model.sv
// bus partner: tallies bus cycles and stretches each by set wait states
// assumes: BUS_START marks a cycle start, BUS_WAIT is sampled by design
`timescale 1ns/1ps
`default_nettype none
module ict_mem_model (
  // clock and control
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [3:0] waits,
  // processor bus
  input  wire logic       bus_start,
  input  wire logic       bus_read,
  input  wire logic       bus_write,
  output logic            bus_wait,
  // tallies
  output logic [7:0]      n_rd,
  output logic [7:0]      n_wr
);
  logic [3:0] left;
  assign bus_wait = (left != 4'h0);
  always_ff @(posedge clk) begin
    if (clr) begin
      n_rd <= 8'h00;
      n_wr <= 8'h00;
      left <= 4'h0;
    end else begin
      if (bus_start && bus_read) n_rd <= n_rd + 8'h01;
      if (bus_start && bus_write) n_wr <= n_wr + 8'h01;
      if (bus_start) left <= waits;
      else if (left != 4'h0) left <= left - 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: test/instruction_cycle_timing_test.sv
// bench: drives operation requests, checks clocks and bus cycle tallies
// assumes: partner model on the bus, inputs driven at falling edges
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_test;
  import ict_pkg::*;
  localparam logic [4:0] F0 = 5'h00, FL = 5'h10, FM = 5'h08;
  localparam logic [4:0] FS = 5'h04, FA = 5'h02, FB = 5'h01;
  logic CLK, RESET_N, CLK_EN, RELEASED, REQ_VALID, REQ_READY;
  logic BUS_WAIT, BUS_READ, BUS_WRITE, BUS_START, BUSY, DONE;
  logic FIRST_FETCH, clr;
  logic [CNT_W-1:0] CLK_COUNT;
  logic [7:0] n_rd, n_wr;
  logic [3:0] waits;
  ict_req_t REQ;
  int n_mismatch, n_compared;

  ict_sequencer #(.MAX_REGS(16)) DUT (.CLK(CLK), .RESET_N(RESET_N),
    .CLK_EN(CLK_EN), .RELEASED(RELEASED), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .BUS_WAIT(BUS_WAIT),
    .BUS_READ(BUS_READ), .BUS_WRITE(BUS_WRITE), .BUS_START(BUS_START),
    .BUSY(BUSY), .DONE(DONE), .FIRST_FETCH(FIRST_FETCH),
    .CLK_COUNT(CLK_COUNT));
  ict_mem_model mem (.clk(CLK), .clr(clr), .waits(waits),
    .bus_start(BUS_START), .bus_read(BUS_READ), .bus_write(BUS_WRITE),
    .bus_wait(BUS_WAIT), .n_rd(n_rd), .n_wr(n_wr));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one request: flags {long,mem,static,alt,alt2}, expected totals without waits
  task op(input ict_op_t o, input logic [4:0] f, input logic [4:0] n,
          input logic [11:0] ec, input logic [7:0] er,
          input logic [11:0] xc, input logic [7:0] xr, input logic [7:0] xw);
    int k;
    k = 0;
    @(negedge CLK);
    while (REQ_READY !== 1'b1 && k < 400) begin
      @(negedge CLK);
      k++;
    end
    if (k >= 400) n_mismatch++;
    clr = 1'b1;
    REQ = '{o, f[4], f[3], f[2], f[1], f[0], n, ec, er};
    REQ_VALID = 1'b1;
    @(negedge CLK);
    clr = 1'b0;
    REQ_VALID = 1'b0;
    k = 0;
    while (DONE !== 1'b1 && k < 600) begin
      @(negedge CLK);
      k++;
    end
    if (k >= 600) n_mismatch++;
    chk({o.name(), " clks"}, CLK_COUNT, xc + waits * (xr + xw));
    chk({o.name(), " reads"}, {4'h0, n_rd}, {4'h0, xr});
    chk({o.name(), " writes"}, {4'h0, n_wr}, {4'h0, xw});
  endtask

  task t_start;
    int k;
    k = 0;
    @(negedge CLK);
    RESET_N = 1'b1;
    repeat (2) @(negedge CLK);
    clr = 1'b0;
    RELEASED = 1'b1;
    while (FIRST_FETCH !== 1'b1 && k < 200) begin
      @(negedge CLK);
      k++;
    end
    if (k >= 200) n_mismatch++;
    chk("startup clks", CLK_COUNT, 12'h028);
    chk("startup reads", {4'h0, n_rd}, 12'h006);
    chk("startup writes", {4'h0, n_wr}, 12'h000);
    $display("test startup done");
  endtask

  task t_bits;
    op(ICT_BIT_INVERT, F0, 0, 0, 0, 8, 1, 0);
    op(ICT_BIT_ONE, FS, 0, 0, 0, 12, 2, 0);
    op(ICT_BIT_INVERT, FM, 0, 4, 1, 12, 2, 1);
    op(ICT_BIT_ONE, FM | FS, 0, 8, 2, 20, 4, 1);
    op(ICT_BIT_ZERO, F0, 0, 0, 0, 10, 1, 0);
    op(ICT_BIT_ZERO, FS, 0, 0, 0, 14, 2, 0);
    op(ICT_BIT_ZERO, FM, 0, 4, 1, 12, 2, 1);
    op(ICT_BIT_PROBE, F0, 0, 0, 0, 6, 1, 0);
    op(ICT_BIT_PROBE, FS, 0, 0, 0, 10, 2, 0);
    op(ICT_BIT_PROBE, FM, 0, 4, 1, 8, 2, 0);
    op(ICT_BIT_PROBE, FM | FS, 0, 4, 1, 12, 3, 0);
    $display("test bits done");
  endtask

  task t_branch;
    op(ICT_COND_BRANCH, FA, 0, 0, 0, 10, 2, 0);
    op(ICT_COND_BRANCH, F0, 0, 0, 0, 8, 1, 0);
    op(ICT_COND_BRANCH, FL, 0, 0, 0, 12, 2, 0);
    op(ICT_ALWAYS_BRANCH, F0, 0, 0, 0, 10, 2, 0);
    op(ICT_BRANCH_CALL, F0, 0, 0, 0, 18, 2, 2);
    op(ICT_COUNT_LOOP, FA, 0, 0, 0, 12, 2, 0);
    op(ICT_COUNT_LOOP, F0, 0, 0, 0, 10, 2, 0);
    op(ICT_COUNT_LOOP, FB, 0, 0, 0, 14, 3, 0);
    op(ICT_JUMP, F0, 0, 0, 0, 8, 2, 0);
    op(ICT_CALL, F0, 0, 0, 0, 16, 2, 2);
    op(ICT_CALL, FA, 0, 0, 0, 20, 3, 2);
    op(ICT_ADDR_LOAD, F0, 0, 0, 0, 4, 1, 0);
    op(ICT_ADDR_PUSH, F0, 0, 0, 0, 12, 1, 2);
    $display("test branch done");
  endtask

  task t_multi;
    op(ICT_MULTI_LOAD, F0, 3, 0, 0, 24, 6, 0);
    op(ICT_MULTI_LOAD, FL, 16, 0, 0, 140, 35, 0);
    op(ICT_MULTI_LOAD, F0, 20, 0, 0, 76, 19, 0);
    op(ICT_MULTI_STORE, F0, 1, 0, 0, 12, 2, 1);
    op(ICT_MULTI_STORE, FL, 2, 0, 0, 24, 2, 4);
    $display("test multi done");
  endtask

  task t_misc;
    op(ICT_EXT_ADD, FL, 0, 0, 0, 8, 1, 0);
    op(ICT_EXT_SUB, FM | FL, 0, 0, 0, 30, 5, 2);
    op(ICT_MEM_COMPARE, FL, 0, 0, 0, 20, 5, 0);
    op(ICT_DEC_ADD, FM, 0, 0, 0, 18, 3, 1);
    op(ICT_DEC_SUB, F0, 0, 0, 0, 6, 1, 0);
    op(ICT_LOGIC_IMM_STATUS, F0, 0, 0, 0, 20, 3, 0);
    op(ICT_STATUS_LOAD, F0, 0, 0, 0, 12, 2, 0);
    op(ICT_CC_LOAD, F0, 0, 0, 0, 12, 1, 0);
    op(ICT_STATUS_STORE, F0, 0, 0, 0, 6, 1, 0);
    op(ICT_EXT_RESET, F0, 0, 0, 0, 132, 1, 0);
    op(ICT_EXC_RETURN, F0, 0, 0, 0, 20, 5, 0);
    op(ICT_CC_RESTORE_RETURN, F0, 0, 0, 0, 20, 2, 0);
    op(ICT_SUB_RETURN, F0, 0, 0, 0, 16, 4, 0);
    op(ICT_FRAME_ALLOC, F0, 0, 0, 0, 16, 2, 2);
    op(ICT_FRAME_FREE, F0, 0, 0, 0, 12, 3, 0);
    op(ICT_STOP, F0, 0, 0, 0, 4, 0, 0);
    op(ICT_IDLE, F0, 0, 0, 0, 4, 1, 0);
    op(ICT_REG_EXCHANGE, F0, 0, 0, 0, 6, 1, 0);
    op(ICT_BOUNDS_CHECK, F0, 0, 4, 1, 14, 2, 0);
    op(ICT_PERIPH_MOVE, FL, 0, 0, 0, 24, 2, 4);
    op(ICT_PERIPH_MOVE, FA, 0, 0, 0, 16, 4, 0);
    $display("test misc done");
  endtask

  task t_exc;
    op(ICT_EXC_ADDR_ERR, F0, 0, 0, 0, 50, 4, 7);
    op(ICT_EXC_BUS_ERR, F0, 0, 0, 0, 50, 4, 7);
    op(ICT_EXC_SIMPLE, F0, 0, 0, 0, 34, 4, 3);
    op(ICT_EXC_BOUNDS, F0, 0, 4, 1, 44, 5, 3);
    op(ICT_EXC_DIV_ZERO, F0, 0, 4, 1, 42, 5, 3);
    op(ICT_EXC_INTERRUPT, F0, 0, 0, 0, 44, 5, 3);
    $display("test exceptions done");
  endtask

  task t_wait;
    waits = 4'h2;
    op(ICT_IDLE, F0, 0, 0, 0, 4, 1, 0);
    waits = 4'h1;
    op(ICT_BRANCH_CALL, F0, 0, 0, 0, 18, 2, 2);
    waits = 4'h0;
    $display("test waits done");
  endtask

  initial begin
    RESET_N = 1'b0;
    CLK_EN = 1'b1;
    RELEASED = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    clr = 1'b1;
    waits = 4'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge CLK);
    t_start;
    t_bits;
    t_branch;
    t_multi;
    t_misc;
    t_exc;
    t_wait;
    end_of_test;
  end

  initial begin
    #1000000;
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
